/* rtl/sdr_map.svh */
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// Register byte offsets
`define SDR_ADDR_STATUS    8'h00
`define SDR_ADDR_MASK      8'h04
`define SDR_ADDR_STATE     8'h08
`define SDR_ADDR_FREQ      8'h0c
`define SDR_ADDR_WORDS     8'h10

// Status and mask bit positions
`define SDR_EV_LOCK_LOST   0
`define SDR_EV_LOCK_GAIN   1
`define SDR_EV_SIG_LOST    2
`define SDR_EV_LONG_RUN    3
`define SDR_EV_W           4

// Reset values
`define SDR_RST_MASK       4'h0
`define SDR_RST_STATUS     4'h0

// Timing: clock rate and lock qualification delay
`define SDR_CLK_MHZ        20
`define SDR_LOCK_DELAY_US  56
`define SDR_LOCK_DELAY_CYC (`SDR_LOCK_DELAY_US * `SDR_CLK_MHZ)

// Frequency detector window and ratios
`define SDR_WIN_EDGES      256
`define SDR_DIV_LO         64
`define SDR_DIV_HI         16
`define SDR_LOSS_PPM       1000
`define SDR_LOCK_PPM       500
`define SDR_PPM_UNIT       1000000

// Oscillator increments per line rate, trim step, mid-bit phase
`define SDR_INC_RATE_LO    24'h400000
`define SDR_INC_RATE_HI    24'h424f76
`define SDR_TRIM_STEP      16'h0100
`define SDR_PHASE_MID      24'h800000

// Tolerated identical bit run
`define SDR_RUN_TOL        11'd2000

`endif

/* rtl/sdr_pkg.sv */
package sdr_pkg;

    // Lock monitor states
    typedef enum logic [1:0] {
        SDR_ACQ,
        SDR_QUAL,
        SDR_LOCK
    } sdr_lock_t;

    // Whole state of the deserializer
    typedef struct packed {
        logic [23:0]        phase;
        logic signed [15:0] trim;
        sdr_lock_t          fsm;
        logic [10:0]        qual;
        logic [8:0]         edges;
        logic [15:0]        ticks;
        logic signed [16:0] diff;
        logic               ref_q;
        logic               ser_q;
        logic               los_q;
        logic               last_bit;
        logic [10:0]        run;
        logic [15:0]        shift;
        logic [3:0]         bit_cnt;
        logic [15:0]        word;
        logic               pclk;
        logic               lock_n;
        logic               sync_err;
        logic [15:0]        words;
        logic [3:0]         status;
        logic [3:0]         mask;
        logic               irq;
        logic               aw_held;
        logic [7:0]         awaddr;
        logic               w_held;
        logic [3:0]         wdata;
        logic               wlane0;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } sdr_state_t;

endpackage

/* rtl/sdr_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module sdr_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } sdr_sync_t;

    sdr_sync_t r;
    sdr_sync_t nx;

    // Three stages; a bit changes once stages two and three agree
    always_comb begin
        nx = r;
        nx.s1 = pin_in;
        nx.s2 = r.s1;
        nx.s3 = r.s2;
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                nx.out[i] = r.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= nx;
        end
    end

    assign pin_out = r.out;

endmodule
`default_nettype wire

/* rtl/sdr_deserializer.sv */
// Notes on behaviour
// - Serial bits are gathered into 16-bit words, one word per sixteen bit times.
// - Line rate pin picks the nominal rate: low the slower, high the faster.
// - Clock select low follows data transitions; high runs purely from the reference.
// - Lock indicator goes low when the frequency error exceeds 1000 ppm.
// - Lock indicator goes high only when error is within 500 ppm.
// - After frequency lock the indicator rises about 56 us later.
// - Frequency detector steers the oscillator by the sign of the error.
// - Holdover keeps the parallel clock running from the reference while lock is lost.
// - Long identical bit runs do not disturb the oscillator frequency.
// - Signal lost input low forces holdover; tie high when unused.
// - Reference divide pin: low means line rate over 64, high over 16.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`include "sdr_map.svh"
`timescale 1ns/10ps
`default_nettype none

module sdr_deserializer (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // Line and strap pins
    input  wire logic        serial_line_in,
    input  wire logic        reference_clock_in,
    input  wire logic        clock_source_sel,
    input  wire logic        line_rate_sel,
    input  wire logic        ref_divide_sel,
    input  wire logic        signal_lost_in_n,
    // Parallel side and status pins
    output logic             parallel_clock_out,
    output logic [15:0]      parallel_word_out,
    output logic             lock_lost_n,
    output logic             sync_err,
    output logic             irq,
    // AXI4-Lite write
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    localparam logic [15:0] EXP_LO  = 16'(`SDR_WIN_EDGES * `SDR_DIV_LO);
    localparam logic [15:0] EXP_HI  = 16'(`SDR_WIN_EDGES * `SDR_DIV_HI);
    localparam logic [16:0] LOSS_LO = 17'(`SDR_WIN_EDGES * `SDR_DIV_LO * `SDR_LOSS_PPM / `SDR_PPM_UNIT);
    localparam logic [16:0] LOSS_HI = 17'(`SDR_WIN_EDGES * `SDR_DIV_HI * `SDR_LOSS_PPM / `SDR_PPM_UNIT);
    localparam logic [16:0] LOCK_LO = 17'(`SDR_WIN_EDGES * `SDR_DIV_LO * `SDR_LOCK_PPM / `SDR_PPM_UNIT);
    localparam logic [16:0] LOCK_HI = 17'(`SDR_WIN_EDGES * `SDR_DIV_HI * `SDR_LOCK_PPM / `SDR_PPM_UNIT);
    localparam logic [10:0] QUAL_N  = 11'(`SDR_LOCK_DELAY_CYC);
    localparam logic [8:0]  WIN_END = 9'(`SDR_WIN_EDGES - 1);

    sdr_pkg::sdr_state_t r;
    sdr_pkg::sdr_state_t nx;

    logic [5:0]         pins_s;
    logic               ser_s;
    logic               ref_s;
    logic               sel_s;
    logic               rate_s;
    logic               div_s;
    logic               los_s;
    logic [23:0]        inc;
    logic               tick;
    logic               trans;
    logic               ref_edge;
    logic               win_end;
    logic [15:0]        expect_cnt;
    logic [15:0]        seen_cnt;
    logic signed [16:0] win_diff;
    logic [16:0]        abs_diff;
    logic               too_far;
    logic               near_ok;
    logic [3:0]         ev;
    logic [3:0]         clr;
    logic [31:0]        rd_word;
    logic               rd_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    sdr_pin_sync #(
        .W(6)
    ) u_pins (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin_in  ({serial_line_in, reference_clock_in, clock_source_sel,
                   line_rate_sel, ref_divide_sel, signal_lost_in_n}),
        .pin_out (pins_s)
    );

    assign {ser_s, ref_s, sel_s, rate_s, div_s, los_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nx = r;
        // Oscillator increment from rate strap plus frequency trim
        inc = (rate_s ? `SDR_INC_RATE_HI : `SDR_INC_RATE_LO)
              + {{8{r.trim[15]}}, r.trim};
        {tick, nx.phase} = {1'b0, r.phase} + {1'b0, inc};
        trans = ser_s ^ r.ser_q;
        nx.ser_q = ser_s;
        // Realign only in data mode; reference mode free-runs
        if (trans && !sel_s) begin
            nx.phase = `SDR_PHASE_MID;
        end

        // Bit sampling, word assembly and parallel clock
        ev = '0;
        if (tick) begin
            nx.shift = {r.shift[14:0], ser_s};
            nx.bit_cnt = r.bit_cnt + 4'h1;
            nx.last_bit = ser_s;
            if (ser_s == r.last_bit) begin
                if (r.run != 11'h7ff) begin
                    nx.run = r.run + 11'h001;
                end
            end else begin
                nx.run = '0;
            end
            ev[`SDR_EV_LONG_RUN] = (nx.run == `SDR_RUN_TOL);
            if (r.bit_cnt == 4'hf) begin
                nx.word = {r.shift[14:0], ser_s};
                nx.pclk = 1'b1;
                nx.words = r.words + 16'h0001;
            end else if (r.bit_cnt == 4'h7) begin
                nx.pclk = 1'b0;
            end
        end

        // Frequency window against reference edges
        ref_edge = ref_s & ~r.ref_q;
        nx.ref_q = ref_s;
        win_end = ref_edge && (r.edges == WIN_END);
        seen_cnt = r.ticks + {15'h0, tick};
        expect_cnt = div_s ? EXP_HI : EXP_LO;
        win_diff = $signed({1'b0, expect_cnt}) - $signed({1'b0, seen_cnt});
        abs_diff = win_diff[16] ? 17'(-win_diff) : win_diff;
        too_far = abs_diff > (div_s ? LOSS_HI : LOSS_LO);
        near_ok = abs_diff <= (div_s ? LOCK_HI : LOCK_LO);
        nx.ticks = seen_cnt;
        if (ref_edge) begin
            nx.edges = r.edges + 9'h001;
        end
        if (win_end) begin
            nx.edges = '0;
            nx.ticks = '0;
            nx.diff = win_diff;
            // Slow oscillator speeds up, fast one slows down
            if (win_diff > 0) begin
                nx.trim = r.trim + `SDR_TRIM_STEP;
            end else if (win_diff < 0) begin
                nx.trim = r.trim - `SDR_TRIM_STEP;
            end
        end

        // Lock monitor with hysteresis and qualification delay
        case (r.fsm)
            sdr_pkg::SDR_ACQ: begin
                nx.qual = '0;
                if (win_end && near_ok) begin
                    nx.fsm = sdr_pkg::SDR_QUAL;
                end
            end
            sdr_pkg::SDR_QUAL: begin
                nx.qual = r.qual + 11'h001;
                if (win_end && too_far) begin
                    nx.fsm = sdr_pkg::SDR_ACQ;
                end else if (r.qual == QUAL_N - 11'h001) begin
                    nx.fsm = sdr_pkg::SDR_LOCK;
                end
            end
            sdr_pkg::SDR_LOCK: begin
                if (win_end && too_far) begin
                    nx.fsm = sdr_pkg::SDR_ACQ;
                end
            end
            default: begin
                nx.fsm = sdr_pkg::SDR_ACQ;
            end
        endcase
        nx.lock_n = (nx.fsm == sdr_pkg::SDR_LOCK);
        nx.sync_err = ~nx.lock_n | ~los_s;
        nx.los_q = los_s;
        ev[`SDR_EV_LOCK_LOST] = r.lock_n & ~nx.lock_n;
        ev[`SDR_EV_LOCK_GAIN] = ~r.lock_n & nx.lock_n;
        ev[`SDR_EV_SIG_LOST] = r.los_q & ~los_s;

        // Write channel: address and data taken in either order
        clr = '0;
        if (s_axi_awvalid && r.awready) begin
            nx.aw_held = 1'b1;
            nx.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            nx.w_held = 1'b1;
            nx.wdata = s_axi_wdata[3:0];
            nx.wlane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end
        if (r.aw_held && r.w_held && !r.bvalid) begin
            nx.aw_held = 1'b0;
            nx.w_held = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = 2'h0;
            case (r.awaddr)
                `SDR_ADDR_STATUS: clr = r.wlane0 ? r.wdata : 4'h0;
                `SDR_ADDR_MASK: begin
                    if (r.wlane0) begin
                        nx.mask = r.wdata;
                    end
                end
                `SDR_ADDR_STATE, `SDR_ADDR_FREQ, `SDR_ADDR_WORDS: nx.bresp = 2'h0;
                default: nx.bresp = 2'h2;
            endcase
        end
        nx.awready = ~nx.aw_held & ~nx.bvalid;
        nx.wready = ~nx.w_held & ~nx.bvalid;

        // Sticky status, set wins over write-one clear
        nx.status = (r.status & ~clr) | ev;
        nx.irq = |(nx.status & nx.mask);

        // Read channel
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `SDR_ADDR_STATUS: rd_word = {28'h0, r.status};
            `SDR_ADDR_MASK:   rd_word = {28'h0, r.mask};
            `SDR_ADDR_STATE:  rd_word = {27'h0, r.sync_err, sel_s, r.lock_n, r.fsm};
            `SDR_ADDR_FREQ:   rd_word = {{15{r.diff[16]}}, r.diff};
            `SDR_ADDR_WORDS:  rd_word = {16'h0, r.words};
            default: begin
                rd_word = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
        if (s_axi_rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            nx.rvalid = 1'b1;
            nx.rdata = rd_word;
            nx.rresp = rd_ok ? 2'h0 : 2'h2;
        end
        nx.arready = ~nx.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= nx;
        end
    end

    // Outputs straight from the state
    assign parallel_clock_out = r.pclk;
    assign parallel_word_out  = r.word;
    assign lock_lost_n        = r.lock_n;
    assign sync_err           = r.sync_err;
    assign irq                = r.irq;
    assign s_axi_awready      = r.awready;
    assign s_axi_wready       = r.wready;
    assign s_axi_bvalid       = r.bvalid;
    assign s_axi_bresp        = r.bresp;
    assign s_axi_arready      = r.arready;
    assign s_axi_rvalid       = r.rvalid;
    assign s_axi_rdata        = r.rdata;
    assign s_axi_rresp        = r.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence s_word_due;
        tick && (r.bit_cnt == 4'hf);
    endsequence

    sequence s_far_window;
        win_end && too_far;
    endsequence

    property p_word_clock;
        s_word_due |=> $rose(r.pclk) && (r.word == $past(nx.word));
    endproperty
    a_word_clock: assert property (p_word_clock) else $error("word not aligned to clock");

    property p_word_only_on_clock;
        !$rose(r.pclk) |-> $stable(r.word);
    endproperty
    a_word_only_on_clock: assert property (p_word_only_on_clock) else $error("word moved off clock");

    property p_loss;
        s_far_window ##0 (r.fsm != sdr_pkg::SDR_ACQ) |=> !lock_lost_n;
    endproperty
    a_loss: assert property (p_loss) else $error("lock indicator stayed high");

    property p_rise_needs_qual;
        $rose(lock_lost_n) |-> $past(r.fsm) == sdr_pkg::SDR_QUAL && $past(r.qual) == QUAL_N - 11'h001;
    endproperty
    a_rise_needs_qual: assert property (p_rise_needs_qual) else $error("lock rose early");

    property p_enter_qual;
        (r.fsm == sdr_pkg::SDR_ACQ) && win_end |=> (r.fsm == sdr_pkg::SDR_QUAL) == $past(near_ok);
    endproperty
    a_enter_qual: assert property (p_enter_qual) else $error("hysteresis entry wrong");

    property p_steer;
        win_end && (win_diff > 0) |=> r.trim == $past(r.trim) + `SDR_TRIM_STEP;
    endproperty
    a_steer: assert property (p_steer) else $error("oscillator not sped up");

    property p_ref_mode;
        sel_s && !tick |=> r.phase == $past(r.phase) + $past(inc);
    endproperty
    a_ref_mode: assert property (p_ref_mode) else $error("phase realigned in reference mode");

    property p_holdover;
        !los_s || !nx.lock_n |=> sync_err;
    endproperty
    a_holdover: assert property (p_holdover) else $error("sync error missing");

    property p_los_clear;
        los_s && nx.lock_n |=> !sync_err;
    endproperty
    a_los_clear: assert property (p_los_clear) else $error("sync error stuck");

    property p_ratio;
        win_end |-> expect_cnt == (div_s ? 16'h1000 : 16'h4000);
    endproperty
    a_ratio: assert property (p_ratio) else $error("window ratio wrong");

    property p_run_trim;
        !win_end |=> $stable(r.trim);
    endproperty
    a_run_trim: assert property (p_run_trim) else $error("trim moved without window");

endmodule
`default_nettype wire

/* bench/sdr_far_end.sv */
`timescale 1ns/10ps
`default_nettype none

module sdr_far_end (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Parallel side of the receiver
    input  wire logic        parallel_clock_out,
    input  wire logic [15:0] parallel_word_out,
    input  wire logic        sync_err,
    output logic             clock_source_sel,
    // Observations for the bench
    output logic [15:0]      last_word,
    output logic [31:0]      word_count,
    output logic [31:0]      last_gap,
    output logic [31:0]      order_faults
);
    logic        pclk_q;
    logic [15:0] word_q;
    logic [31:0] gap;

    // Holdover wiring, sync error straight to clock select
    assign clock_source_sel = sync_err;

    // Capture one word per rising parallel clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            pclk_q <= 1'b0;
            word_q <= 16'h0;
            gap <= 32'h0;
            last_word <= 16'h0;
            last_gap <= 32'h0;
            word_count <= 32'h0;
            order_faults <= 32'h0;
        end else begin
            pclk_q <= parallel_clock_out;
            word_q <= parallel_word_out;
            gap <= gap + 32'h1;
            if (parallel_clock_out && !pclk_q) begin
                last_word <= parallel_word_out;
                last_gap <= gap + 32'h1;
                gap <= 32'h0;
                word_count <= word_count + 32'h1;
            end else if (parallel_word_out !== word_q) begin
                order_faults <= order_faults + 32'h1;
            end
        end
    end
endmodule

`default_nettype wire

/* bench/testbench.sv */
`include "sdr_map.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        aclk, aresetn, serial_line_in, reference_clock_in, clock_source_sel, line_rate_sel;
    logic        ref_divide_sel, signal_lost_in_n, parallel_clock_out, lock_lost_n, sync_err, irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] parallel_word_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] last_word;
    logic [31:0] word_count, last_gap, order_faults;
    logic [15:0] pattern;
    logic [3:0]  bit_idx;
    logic [1:0]  bit_div;
    int          ref_cnt, ref_period, cycles, rel, errors, compares;

    sdr_deserializer uut (.aclk, .aresetn, .ce(1'b1), .serial_line_in, .reference_clock_in,
        .clock_source_sel, .line_rate_sel, .ref_divide_sel, .signal_lost_in_n,
        .parallel_clock_out, .parallel_word_out, .lock_lost_n, .sync_err, .irq,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp);

    sdr_far_end far_end (.aclk, .aresetn, .parallel_clock_out, .parallel_word_out, .sync_err,
        .clock_source_sel, .last_word, .word_count, .last_gap, .order_faults);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    always #25 aclk = ~aclk;

    // Serial stream, one bit per four clocks, MSB first
    always @(posedge aclk) begin
        bit_div <= bit_div + 2'd1;
        if (bit_div == 2'd3) begin
            serial_line_in <= pattern[bit_idx];
            bit_idx <= bit_idx - 4'd1;
        end
    end

    // Reference clock, ref_period clocks per cycle
    always @(posedge aclk) begin
        ref_cnt <= (ref_cnt >= ref_period - 1) ? 0 : ref_cnt + 1;
        reference_clock_in <= (ref_cnt < ref_period / 2);
    end

    // Cycle count and hang limit
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison helpers and verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Word is some rotation of the sent pattern
    function automatic logic [31:0] is_rot(input logic [15:0] w);
        logic [31:0] two;
        two = {pattern, pattern};
        is_rot = 32'h0;
        for (int k = 0; k < 16; k++) begin
            if (two[k +: 16] === w) is_rot = 32'h1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite master
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Cycles taken by sixteen words
    task automatic span16(output int s);
        logic [31:0] n;
        n = word_count;
        while (word_count == n) @(posedge aclk);
        s = cycles;
        while (word_count < n + 32'd17) @(posedge aclk);
        s = cycles - s;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(`SDR_ADDR_MASK, d, r);
        check(d, 32'h0);
        axi_read(8'h20, d, r);
        check({d[29:0], r}, 32'h2);
        axi_write(8'h20, 32'h1, r);
        check({30'h0, r}, 32'h2);
        axi_write(`SDR_ADDR_MASK, 32'h2, r);
    endtask

    task automatic test_lock();
        logic [31:0] d;
        logic [1:0]  r;
        while (lock_lost_n !== 1'b1) @(posedge aclk);
        // First window is cut short by reset, so lock follows the second
        check_range(cycles - rel, 33700, 34000);
        repeat (4) @(posedge aclk);
        check({31'h0, sync_err}, 32'h0);
        check({31'h0, irq}, 32'h1);
        axi_write(`SDR_ADDR_MASK, 32'h0, r);
        @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        axi_write(`SDR_ADDR_MASK, 32'h2, r);
        @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        axi_write(`SDR_ADDR_STATUS, 32'h2, r);
        @(posedge aclk);
        check({31'h0, irq}, 32'h0);
    endtask

    task automatic test_data();
        logic [31:0] n;
        n = word_count;
        while (word_count < n + 32'd4) @(posedge aclk);
        check_range(last_gap, 63, 65);
        check(is_rot(last_word), 32'h1);
        check(order_faults, 32'h0);
    endtask

    task automatic test_signal_lost();
        logic [31:0] d;
        logic [1:0]  r;
        signal_lost_in_n <= 1'b0;
        repeat (8) @(posedge aclk);
        check({31'h0, sync_err}, 32'h1);
        axi_read(`SDR_ADDR_STATUS, d, r);
        check({31'h0, d[2]}, 32'h1);
        signal_lost_in_n <= 1'b1;
        repeat (8) @(posedge aclk);
        check({31'h0, sync_err}, 32'h0);
        axi_write(`SDR_ADDR_STATUS, 32'h4, r);
        axi_read(`SDR_ADDR_STATUS, d, r);
        check({31'h0, d[2]}, 32'h0);
    endtask

    task automatic test_run();
        logic [31:0] d;
        logic [1:0]  r;
        pattern <= 16'h0;
        repeat (7600) @(posedge aclk);
        axi_read(`SDR_ADDR_STATUS, d, r);
        check({31'h0, d[3]}, 32'h0);
        repeat (600) @(posedge aclk);
        axi_read(`SDR_ADDR_STATUS, d, r);
        check({31'h0, d[3]}, 32'h1);
        check({31'h0, lock_lost_n}, 32'h1);
        pattern <= 16'h1e35;
    endtask

    task automatic test_loss();
        logic [31:0] d;
        logic [31:0] n;
        logic [1:0]  r;
        int          t;
        ref_period <= 60;
        t = cycles;
        while (lock_lost_n !== 1'b0) @(posedge aclk);
        check_range(cycles - t, 1, 34000);
        repeat (4) @(posedge aclk);
        check({31'h0, sync_err}, 32'h1);
        axi_read(`SDR_ADDR_STATE, d, r);
        check({31'h0, d[3]}, 32'h1);
        axi_read(`SDR_ADDR_FREQ, d, r);
        check_range(d, 5, 256);
        n = word_count;
        repeat (300) @(posedge aclk);
        check_range(word_count - n, 4, 5);
    endtask

    task automatic test_rate();
        int s;
        int e;
        span16(s);
        e = 64'd256 * (64'd1 << 24) / `SDR_INC_RATE_LO;
        check_range(s, e - 2, e + 2);
        line_rate_sel <= 1'b1;
        repeat (20) @(posedge aclk);
        span16(s);
        e = 64'd256 * (64'd1 << 24) / `SDR_INC_RATE_HI;
        check_range(s, e - 2, e + 2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        serial_line_in = 1'b0;
        reference_clock_in = 1'b0;
        line_rate_sel = 1'b0;
        ref_divide_sel = 1'b1;
        signal_lost_in_n = 1'b1;
        s_axi_awvalid = 1'b0;
        s_axi_awaddr = 8'h0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_araddr = 8'h0;
        s_axi_rready = 1'b0;
        pattern = 16'h1e35;
        bit_idx = 4'hf;
        bit_div = 2'd0;
        ref_cnt = 0;
        ref_period = 64;
        cycles = 0;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rel = cycles;
        test_regs();
        test_lock();
        test_data();
        test_signal_lost();
        test_run();
        test_loss();
        test_rate();
        final_report();
    end
endmodule

`default_nettype wire
